// ==== fwd_link_model.sv ====
`timescale 1ns/1ps
module fwd_link_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        en_i,
  input  wire logic [2:0]  hold_i,
  output logic      [2:0]  start_o,
  output logic      [15:0] n_start_o
);
  logic [2:0] gap;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_o <= 3'h0;
      n_start_o <= 16'h0000;
      gap <= 3'h0;
    end else if (gap != 3'h0) begin
      start_o <= 3'h0;
      gap <= gap - 3'h1;
    end else if (en_i && !hold_i[0]) begin
      start_o <= 3'h1;
      n_start_o <= n_start_o + 16'h0001;
      gap <= 3'h4;
    end
  end
endmodule // fwd_link_model

// ==== fwd_params.svh ====
`ifndef FWD_PARAMS_SVH
`define FWD_PARAMS_SVH
`define REG_GLOBAL3      12'h00c
`define REG_GLOBAL5      12'h014
`define REG_GLOBAL14     12'h038
`define REG_PORT1_CTRL   12'h044
`define REG_PORT2_CTRL   12'h084
`define REG_PORT3_CTRL   12'h0c4
`define REG_RATE_BASE    12'h100
`define REG_STATUS       12'h140
`define REG_IDX_GLOBAL3  8'h03
`define REG_IDX_GLOBAL5  8'h05
`define REG_IDX_GLOBAL14 8'h0e
`define REG_IDX_PORT1    8'h11
`define REG_IDX_PORT2    8'h21
`define REG_IDX_PORT3    8'h31
`define BIT_TAIL_EN      6
`define BIT_AND_MIRROR   0
`define BIT_UNK_EN       0
`define BIT_UNK_FWD      1
`define BIT_RX_SNIFF     0
`define BIT_TX_SNIFF     1
`define BIT_SNIFFER      2
`define BIT_BAD_SNIFF    3
`define BIT_SIZE_IFG     4
`define BIT_SIZE_PRE     5
`define BIT_SPEED10      6
`define IP_VER_V4        4'h4
`define IP_PROTO_IGMP    8'h02
`define IFG_BYTES        16'h000c
`define PRE_BYTES        16'h0008
`define RATE_FINE_MAX    8'h0f
`define RATE_10M_MAX     8'h19
`define LEAK_SCALE       32'h0000_2000
`define KBPS_STEP        32'h0000_0040
`define KBPS_MBPS        32'h0000_03e8
`define CLK_KHZ          32'h0001_86a0
`define PORT_P1          3'h1
`define PORT_P2          3'h2
`define PORT_P3          3'h4
`define TAG_LOOKUP       2'h0
`define TAG_P1           2'h1
`define TAG_P2           2'h2
`define TAG_BOTH         2'h3
`endif

// ==== fwd_pkg.sv ====
package fwd_pkg;
  typedef struct packed {
    logic       valid;
    logic [1:0] src;
    logic [2:0] lookup;
    logic       lookup_hit;
    logic       unicast;
    logic       multicast;
    logic       broadcast;
    logic       is_ip;
    logic [3:0] ip_ver;
    logic [7:0] ip_proto;
    logic       bad;
    logic [15:0] len;
    logic [1:0] prio;
    logic       has_tag;
    logic [7:0] tag;
  } frame_req_t;
  typedef struct packed {
    logic       valid;
    logic       drop;
    logic [2:0] dest;
    logic       tag_add;
    logic [7:0] tag;
    logic       tag_strip;
    logic [1:0] prio;
  } frame_dec_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECIDE = 2'b01,
    ST_OUT = 2'b10
  } fwd_state_t;
endpackage

// ==== switch_forwarding_policy.sv ====
// How it works
// RULE1 - ipv4 frames with protocol 2 are trapped to processor port only
// RULE2 - tag mode appends a tag to processor frames, bit 0 names ingress port
// RULE3 - processor steers replies with tag bits 1:0, tag stripped on egress
// RULE4 - global 3 bit 6 enables tag mode; clear means no tag either way
// RULE5 - tag 00 lookup, 01 port1, 10 port2, 11 both; bits 3:2 priority
// RULE6 - rx-mirrored port frames are also copied to the sniffer port
// RULE7 - per-port option lets bad frames on rx-mirrored ports reach sniffer
// RULE8 - frames sent out of tx-mirrored ports are copied to the sniffer
// RULE9 - global 5 bit 0 mirrors only rx-mirrored source and tx-mirrored dest
// RULE10 - rx, tx and sniffer selects are per-port in registers 17, 33, 49
// RULE11 - rate code below 16 is 64 kbps steps, above is 1 mbps steps
// RULE12 - separate ingress and egress rates per port and per priority
// RULE13 - on a 10 mbps port a rate above 10 mbps means unlimited
// RULE14 - frame charge is da to fcs, optionally plus ifg or preamble
// RULE15 - ingress metering counts only the selected frame class
// RULE16 - selected frames over the ingress limit are dropped at ingress
// RULE17 - each egress queue is leaky-bucket shaped by stretching the gap
// RULE18 - when egress buffers are full, drop or flow control at ingress
// RULE19 - software should keep egress bandwidth above ingress bandwidth
// RULE20 - unknown unicast is not learned, filtered or forwarded per global 14
// RULE21 - sniffer gets one copy even if it is already a destination
`timescale 1ns/1ps
`include "fwd_params.svh"
module switch_forwarding_policy (
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire fwd_pkg::apb_req_t  apb_i,
  output fwd_pkg::apb_rsp_t       apb_o,
  input  wire fwd_pkg::frame_req_t frame_i,
  output fwd_pkg::frame_dec_t     dec_o,
  input  wire logic [2:0]         tx_start_i,
  input  wire logic [15:0]        tx_len_i,
  input  wire logic [1:0]         tx_prio_i,
  output logic [2:0]              tx_hold_o,
  input  wire logic [2:0]         buf_full_i,
  output logic [2:0]              pause_o,
  output logic                    learn_block_o
);
  import fwd_pkg::*;

  typedef struct packed {
    fwd_state_t  st;
    apb_rsp_t    apb;
    logic [7:0]  g3;
    logic [7:0]  g5;
    logic [7:0]  g14;
    logic [2:0][7:0] pctl;
    logic [2:0][3:0][7:0] in_rate;
    logic [2:0][3:0][7:0] eg_rate;
    logic [2:0][1:0] in_class;
    logic        flow_mode;
    frame_req_t  req;
    frame_dec_t  dec;
    logic [2:0][3:0][31:0] in_bkt;
    logic [2:0][3:0][31:0] eg_bkt;
    logic [2:0]  hold;
    logic [2:0]  pause;
    logic        learn_block;
    logic [15:0] drop_cnt;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic [31:0] rate_kbps(input logic [7:0] code, input logic speed10);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (code == 8'h00) begin
      r = 32'h0000_0000;
    end else if (code <= `RATE_FINE_MAX) begin // RULE11
      r = {24'h0000_00, code} * `KBPS_STEP;
    end else if (speed10 && code > `RATE_10M_MAX) begin // RULE13
      r = 32'h0000_0000;
    end else begin
      r = ({24'h0000_00, code} - 32'h0000_000f) * `KBPS_MBPS; // RULE11
    end
    return r;
  endfunction

  function automatic logic [31:0] frame_charge(input logic [15:0] len, input logic [7:0] pc);
    logic [15:0] b;
    b = len; // RULE14
    if (pc[`BIT_SIZE_IFG]) begin
      b = b + `IFG_BYTES;
    end
    if (pc[`BIT_SIZE_PRE]) begin
      b = b + `PRE_BYTES;
    end
    return {b, 16'h0000};
  endfunction

  function automatic logic [31:0] leak_step(input logic [7:0] code, input logic speed10);
    logic [31:0] k;
    logic [31:0] l;
    k = rate_kbps(code, speed10);
    l = 32'hffff_ffff; // unlimited drains at once
    if (k != 32'h0000_0000) begin
      l = (k * `LEAK_SCALE) / `CLK_KHZ; // RULE11
    end
    return l;
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    logic m;
    m = 1'b0;
    case (a)
      `REG_GLOBAL3: m = 1'b1;
      `REG_GLOBAL5: m = 1'b1;
      `REG_GLOBAL14: m = 1'b1;
      `REG_PORT1_CTRL: m = 1'b1;
      `REG_PORT2_CTRL: m = 1'b1;
      `REG_PORT3_CTRL: m = 1'b1;
      `REG_STATUS: m = 1'b1;
      default: m = a >= `REG_RATE_BASE && a < `REG_RATE_BASE + 12'h030;
    endcase
    return m;
  endfunction

  function automatic logic [2:0] steer_dest(input logic [1:0] sel, input logic [2:0] lookup);
    logic [2:0] d;
    d = lookup;
    case (sel) // RULE5
      `TAG_P1: d = `PORT_P1;
      `TAG_P2: d = `PORT_P2;
      `TAG_BOTH: d = `PORT_P1 | `PORT_P2;
      default: d = lookup;
    endcase
    return d;
  endfunction

  function automatic logic class_hit(input logic [1:0] cls, input frame_req_t r);
    logic h;
    h = 1'b0;
    case (cls) // RULE15
      2'h0: h = 1'b1;
      2'h1: h = r.multicast;
      2'h2: h = r.broadcast;
      default: h = r.unicast && !r.lookup_hit;
    endcase
    return h;
  endfunction

  function automatic logic is_igmp(input frame_req_t r);
    return r.is_ip && r.ip_ver == `IP_VER_V4 && r.ip_proto == `IP_PROTO_IGMP; // RULE1
  endfunction

  function automatic logic mirror_hit(input logic and_mode, input logic rx_sel, input logic bad_ok,
                                      input logic [2:0] d, input logic [2:0] tx_sel);
    logic h;
    if (and_mode) begin
      h = rx_sel && |(d & tx_sel); // RULE9
    end else begin
      h = (rx_sel && bad_ok) || |(d & tx_sel); // RULE6 RULE7 RULE8
    end
    return h;
  endfunction

  logic [11:0] addr;
  logic        acc;
  logic [31:0] rdata;
  logic [1:0]  sp;
  logic [2:0]  dest;
  logic [2:0]  rxm;
  logic [2:0]  txm;
  logic [2:0]  snf;
  logic        mirror;
  logic        igmp;
  logic        sel_class;
  logic [31:0] lim;
  logic [31:0] charge;
  logic [31:0] leak;
  integer      p;
  integer      q;

  always_comb begin
    next_s = s;
    addr = apb_i.paddr;
    acc = apb_i.psel && apb_i.penable;
    rdata = 32'h0000_0000;
    sp = 2'h0;
    dest = 3'h0;
    mirror = 1'b0;
    igmp = 1'b0;
    sel_class = 1'b0;
    lim = 32'h0000_0000;
    charge = 32'h0000_0000;
    leak = 32'h0000_0000;
    for (p = 0; p < 3; p++) begin
      rxm[p] = s.pctl[p][`BIT_RX_SNIFF]; // RULE10
      txm[p] = s.pctl[p][`BIT_TX_SNIFF];
      snf[p] = s.pctl[p][`BIT_SNIFFER];
    end
    // apb slave, zero wait state
    next_s.apb.pready = 1'b0;
    next_s.apb.pslverr = 1'b0;
    if (apb_i.psel && !apb_i.penable) begin
      next_s.apb.pready = 1'b1;
    end
    if (acc && s.apb.pready) begin
      next_s.apb.pready = 1'b0;
    end
    case (addr)
      `REG_GLOBAL3: rdata = {24'h0000_00, s.g3};
      `REG_GLOBAL5: rdata = {24'h0000_00, s.g5};
      `REG_GLOBAL14: rdata = {24'h0000_00, s.g14};
      `REG_PORT1_CTRL: rdata = {22'h0000_00, s.in_class[0], s.pctl[0]};
      `REG_PORT2_CTRL: rdata = {22'h0000_00, s.in_class[1], s.pctl[1]};
      `REG_PORT3_CTRL: rdata = {22'h0000_00, s.in_class[2], s.pctl[2]};
      `REG_STATUS: rdata = {13'h0000, s.pause, s.drop_cnt};
      default: begin
        if (addr >= `REG_RATE_BASE && addr < `REG_RATE_BASE + 12'h030) begin
          p = 32'(addr[5:2]) / 4;
          rdata = {s.eg_rate[p[1:0]][addr[3:2]], 8'h00, s.in_rate[p[1:0]][addr[3:2]], 8'h00};
        end
      end
    endcase
    next_s.apb.prdata = rdata;
    if (acc && s.apb.pready) begin
      if (apb_i.pwrite) begin
        case (addr)
          `REG_GLOBAL3: next_s.g3 = apb_i.pwdata[7:0]; // RULE4
          `REG_GLOBAL5: next_s.g5 = apb_i.pwdata[7:0]; // RULE9
          `REG_GLOBAL14: next_s.g14 = apb_i.pwdata[7:0]; // RULE20
          `REG_PORT1_CTRL: {next_s.in_class[0], next_s.pctl[0]} = apb_i.pwdata[9:0];
          `REG_PORT2_CTRL: {next_s.in_class[1], next_s.pctl[1]} = apb_i.pwdata[9:0];
          `REG_PORT3_CTRL: {next_s.in_class[2], next_s.pctl[2]} = apb_i.pwdata[9:0];
          `REG_STATUS: next_s.flow_mode = apb_i.pwdata[31];
          default: begin
            if (addr >= `REG_RATE_BASE && addr < `REG_RATE_BASE + 12'h030) begin
              p = 32'(addr[5:2]) / 4;
              next_s.in_rate[p[1:0]][addr[3:2]] = apb_i.pwdata[15:8]; // RULE12
              next_s.eg_rate[p[1:0]][addr[3:2]] = apb_i.pwdata[31:24]; // RULE12
            end else if (!(addr inside {`REG_GLOBAL3, `REG_GLOBAL5, `REG_GLOBAL14})) begin
              next_s.apb.pslverr = 1'b1;
            end
          end
        endcase
      end
    end
    if (apb_i.psel && !apb_i.penable) begin
      next_s.apb.pslverr = !reg_mapped(addr);
    end
    // bucket leak every cycle
    for (p = 0; p < 3; p++) begin
      for (q = 0; q < 4; q++) begin
        leak = leak_step(s.in_rate[p][q], s.pctl[p][`BIT_SPEED10]);
        next_s.in_bkt[p][q] = (s.in_bkt[p][q] > leak) ? s.in_bkt[p][q] - leak : 32'h0000_0000;
        leak = leak_step(s.eg_rate[p][q], s.pctl[p][`BIT_SPEED10]);
        next_s.eg_bkt[p][q] = (s.eg_bkt[p][q] > leak) ? s.eg_bkt[p][q] - leak : 32'h0000_0000;
      end
    end
    // egress shaping
    for (p = 0; p < 3; p++) begin
      if (tx_start_i[p] && s.eg_rate[p][tx_prio_i] != 8'h00 &&
          rate_kbps(s.eg_rate[p][tx_prio_i], s.pctl[p][`BIT_SPEED10]) != 32'h0000_0000) begin
        next_s.eg_bkt[p][tx_prio_i] = next_s.eg_bkt[p][tx_prio_i] + frame_charge(tx_len_i, s.pctl[p]); // RULE17
      end
      next_s.hold[p] = next_s.eg_bkt[p][tx_prio_i] != 32'h0000_0000; // RULE17
      next_s.pause[p] = s.flow_mode && buf_full_i[p]; // RULE18
    end
    next_s.dec.valid = 1'b0;
    next_s.learn_block = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (frame_i.valid) begin
          next_s.req = frame_i;
          next_s.st = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        sp = s.req.src;
        dest = s.req.lookup;
        igmp = is_igmp(s.req); // RULE1
        next_s.dec.tag_strip = 1'b0;
        next_s.dec.tag_add = 1'b0;
        next_s.dec.tag = 8'h00;
        next_s.dec.prio = s.req.prio;
        if (sp == 2'h2 && s.g3[`BIT_TAIL_EN] && s.req.has_tag) begin // RULE4
          next_s.dec.tag_strip = 1'b1; // RULE3
          next_s.dec.prio = s.req.tag[3:2]; // RULE5
          dest = steer_dest(s.req.tag[1:0], s.req.lookup); // RULE5
        end else if (igmp && sp != 2'h2) begin
          dest = `PORT_P3; // RULE1
        end else if (s.req.unicast && !s.req.lookup_hit) begin
          next_s.learn_block = 1'b1; // RULE20
          if (s.g14[`BIT_UNK_EN]) begin
            dest = s.g14[`BIT_UNK_FWD] ? (3'h7 & ~(3'h1 << sp)) : 3'h0; // RULE20
          end
        end
        if (s.req.bad) begin
          dest = 3'h0;
        end
        mirror = mirror_hit(s.g5[`BIT_AND_MIRROR], rxm[sp], !s.req.bad || s.pctl[sp][`BIT_BAD_SNIFF],
                            dest, txm); // RULE6 RULE7 RULE8 RULE9
        if (mirror) begin
          dest = dest | snf; // RULE21
        end
        sel_class = class_hit(s.in_class[sp], s.req); // RULE15
        lim = rate_kbps(s.in_rate[sp][s.req.prio], s.pctl[sp][`BIT_SPEED10]);
        charge = frame_charge(s.req.len, s.pctl[sp]);
        next_s.dec.drop = 1'b0;
        if (sel_class && lim != 32'h0000_0000) begin
          if (s.in_bkt[sp][s.req.prio] > {s.req.len, 16'h0000}) begin
            next_s.dec.drop = 1'b1; // RULE16
            next_s.drop_cnt = s.drop_cnt + 16'h0001;
          end else begin
            next_s.in_bkt[sp][s.req.prio] = next_s.in_bkt[sp][s.req.prio] + charge; // RULE12
          end
        end
        if (!s.flow_mode && |(dest & buf_full_i)) begin
          next_s.dec.drop = 1'b1; // RULE18
        end
        if (dest == 3'h0) begin
          next_s.dec.drop = 1'b1;
        end
        if (|(dest & `PORT_P3) && s.g3[`BIT_TAIL_EN] && sp != 2'h2) begin
          next_s.dec.tag_add = 1'b1; // RULE2
          next_s.dec.tag = {7'h00, sp[0]}; // RULE2
        end
        next_s.dec.dest = dest;
        next_s.dec.valid = 1'b1;
        next_s.st = ST_OUT;
      end
      ST_OUT: next_s.st = ST_IDLE;
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign apb_o = s.apb;
  assign dec_o = s.dec;
  assign tx_hold_o = s.hold;
  assign pause_o = s.pause;
  assign learn_block_o = s.learn_block;
endmodule // switch_forwarding_policy

// ==== switch_forwarding_policy_sva.sv ====
`timescale 1ns/1ps
module fwd_sva (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire fwd_pkg::apb_req_t   apb_i,
  input wire fwd_pkg::apb_rsp_t   apb_o,
  input wire fwd_pkg::frame_req_t frame_i,
  input wire fwd_pkg::frame_dec_t dec_o,
  input wire logic                learn_block_o
);
  import fwd_pkg::*;
  wire igmp = frame_i.valid && frame_i.is_ip && frame_i.ip_ver == 4'h4 && frame_i.ip_proto == 8'h02
              && frame_i.src != 2'h2 && !frame_i.bad;
  wire unk = frame_i.valid && frame_i.unicast && !frame_i.lookup_hit;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_ready_next: assert property (apb_i.psel && !apb_i.penable |=> apb_o.pready)
    else $error("no pready after setup");
  chk_ready_once: assert property (apb_o.pready |=> !apb_o.pready)
    else $error("pready held");
  chk_dec_cause: assert property (dec_o.valid |-> $past(frame_i.valid, 2))
    else $error("decision without frame");
  chk_dec_once: assert property (dec_o.valid |=> !dec_o.valid)
    else $error("decision valid held");
  chk_igmp_trap: assert property (dec_o.valid && $past(igmp, 2) |-> dec_o.drop || dec_o.dest == 3'h4)
    else $error("igmp not trapped");
  chk_tag_src: assert property (dec_o.valid && dec_o.tag_add |->
    dec_o.dest[2] && dec_o.tag[0] == ($past(frame_i.src, 2) == 2'h1))
    else $error("tag source wrong");
  chk_tag_dest: assert property (dec_o.valid && dec_o.tag_strip && $past(frame_i.tag[1:0], 2) != 2'h0
    |-> dec_o.dest[1:0] == $past(frame_i.tag[1:0], 2))
    else $error("tag steer wrong");
  chk_tag_prio: assert property (dec_o.valid && dec_o.tag_strip |-> dec_o.prio == $past(frame_i.tag[3:2], 2))
    else $error("tag priority wrong");
  chk_learn_blk: assert property (learn_block_o |-> $past(unk, 2) || $past(unk, 1))
    else $error("learn block without unknown unicast");
endmodule // fwd_sva
bind switch_forwarding_policy fwd_sva u_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
  .frame_i(frame_i), .dec_o(dec_o), .learn_block_o(learn_block_o));

// ==== switch_forwarding_policy_tb.sv ====
`timescale 1ns/1ps
module switch_forwarding_policy_tb;
  import fwd_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        held = 1'b0;
  apb_req_t    apb_i;
  apb_rsp_t    apb_o;
  frame_req_t  frame_i, f;
  frame_dec_t  dec_o, dq;
  logic [2:0]  tx_start_i, tx_hold_o, buf_full_i, pause_o, rxs, txs;
  logic [15:0] tx_len_i, n_start;
  logic [1:0]  tx_prio_i;
  logic        learn_block_o, link_en, lb, am, se;
  logic [31:0] rd;
  integer      error_cnt = 0, n_tests = 0, nd = 0, i, seed = 32'h192c_9d77;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) held <= link_en && (held || tx_hold_o != 3'h0);
  switch_forwarding_policy u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o),
    .frame_i(frame_i), .dec_o(dec_o), .tx_start_i(tx_start_i), .tx_len_i(tx_len_i), .tx_prio_i(tx_prio_i),
    .tx_hold_o(tx_hold_o), .buf_full_i(buf_full_i), .pause_o(pause_o), .learn_block_o(learn_block_o));
  fwd_link_model u_link (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(link_en), .hold_i(tx_hold_o),
    .start_o(tx_start_i), .n_start_o(n_start));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    while (apb_o.pready !== 1'b1) @(posedge clk_i);
    rd = apb_o.prdata;
    se = apb_o.pslverr;
    apb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic send(input frame_req_t x);
    x.valid = 1'b1;
    frame_i <= x;
    @(posedge clk_i);
    frame_i.valid <= 1'b0;
    lb = 1'b0;
    while (dec_o.valid !== 1'b1) begin
      @(posedge clk_i);
      lb = lb | learn_block_o;
    end
    dq = dec_o;
  endtask
  function automatic frame_req_t mk(input logic [1:0] s, input logic [2:0] l);
    mk = '0;
    mk.src = s;
    mk.lookup = l;
    mk.lookup_hit = 1'b1;
    mk.unicast = 1'b1;
    mk.len = 16'h0040;
  endfunction
  function automatic logic [2:0] exp_dest(input logic [1:0] s, input logic [2:0] l);
    logic m;
    m = am ? rxs[s] && |(l & txs) : rxs[s] || |(l & txs);
    exp_dest = m ? l | 3'h4 : l;
  endfunction
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    test_done;
  end
  initial begin
    apb_i = '0;
    frame_i = '0;
    buf_full_i = 3'h0;
    tx_len_i = 16'h0040;
    tx_prio_i = 2'h1;
    link_en = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk(se, 1'b1);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h00c, {25'h0, i[1], 6'h0});
      f = mk({1'b0, i[0]}, 3'h2 >> i[0]);
      f.is_ip = 1'b1;
      f.ip_ver = 4'h4;
      f.ip_proto = 8'h02;
      send(f);
      chk(dq.dest, 3'h4);
      chk({dq.tag_add, dq.tag[0] & i[1]}, {i[1], i[0] & i[1]});
    end
    $display("trap and tag test done");
    for (i = 0; i < 17; i++) begin
      apb(1'b1, 12'h00c, i < 16 ? 32'h0000_0040 : 32'h0);
      f = mk(2'h2, 3'h3);
      f.has_tag = 1'b1;
      f.tag = i < 16 ? i[7:0] : 8'h01;
      send(f);
      chk(dq.dest, (i < 16 && i[1:0] != 2'h0) ? {1'b0, i[1:0]} : 3'h3);
      chk({dq.tag_strip, dq.prio}, i < 16 ? {1'b1, i[3:2]} : 3'h0);
    end
    $display("steer test done");
    for (i = 0; i < 24; i++) begin
      rxs = 3'($random(seed));
      txs = 3'($random(seed));
      am = 1'($random(seed));
      apb(1'b1, 12'h014, {31'h0, am});
      apb(1'b1, 12'h044, {29'h0, txs[0], rxs[0]});
      apb(1'b1, 12'h084, {29'h0, txs[1], rxs[1]});
      apb(1'b1, 12'h0c4, {29'h1, txs[2], rxs[2]});
      f = mk({1'b0, i[0]}, i[0] ? {i[1], 2'b01} : {i[1], 2'b10});
      send(f);
      chk(dq.dest, exp_dest(f.src, f.lookup));
    end
    apb(1'b1, 12'h014, 32'h0);
    apb(1'b1, 12'h084, 32'h0);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h044, i[0] ? 32'h0000_0001 : 32'h0000_0009);
      f = mk(2'h0, 3'h2);
      f.bad = 1'b1;
      send(f);
      chk(dq.dest, i[0] ? 3'h0 : 3'h4);
    end
    apb(1'b1, 12'h044, 32'h0);
    apb(1'b1, 12'h0c4, 32'h0);
    $display("mirror test done");
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 12'h038, {30'h0, i[0], 1'b1});
      f = mk(2'h0, 3'h6);
      f.lookup_hit = 1'b0;
      send(f);
      chk({dq.drop, lb, i[0] ? dq.dest : 3'h6}, {!i[0], 1'b1, 3'h6});
    end
    apb(1'b1, 12'h038, 32'h0);
    $display("unknown unicast test done");
    apb(1'b1, 12'h100, 32'h0000_0100);
    for (i = 0; i < 12; i++) begin
      if (i % 4 == 0)
        apb(1'b1, 12'h044, i == 0 ? 32'h0000_0200 : i == 4 ? 32'h0 : 32'h0000_0040);
      if (i == 8)
        apb(1'b1, 12'h100, 32'h0000_1a00);
      f = mk(2'h0, 3'h2);
      f.len = 16'h05dc;
      send(f);
      nd = nd + dq.drop;
      if (i % 4 == 3) begin
        chk(nd != 0, i == 7);
        nd = 0;
      end
    end
    $display("ingress rate test done");
    apb(1'b1, 12'h104, 32'h0100_0000);
    link_en <= 1'b1;
    repeat (300) @(posedge clk_i);
    link_en <= 1'b0;
    chk({held, n_start < 16'h0004}, 2'b11);
    apb(1'b1, 12'h140, 32'h8000_0000);
    buf_full_i <= 3'h1;
    for (nd = 0; nd < 20 && pause_o !== 3'h1; nd++) @(posedge clk_i);
    chk(pause_o, 3'h1);
    buf_full_i <= 3'h0;
    $display("egress test done");
    test_done;
  end
endmodule // switch_forwarding_policy_tb
